/* inc/prp_map.svh */
// Register offsets, field positions, reset values and timing counts of the reset and pin block
`ifndef PRP_MAP_SVH
`define PRP_MAP_SVH

// Register offsets
`define PRP_ADDR_REG_PWR 16'h00D0
`define PRP_ADDR_PIN_CFG 16'h00D4
`define PRP_ADDR_IRQ_STAT 16'h00D8
`define PRP_ADDR_IRQ_MASK 16'h00DC
`define PRP_ADDR_STRAP 16'h00E0
`define PRP_ADDR_STATUS 16'h00E4

// Field positions
`define PRP_BIT_REG_OFF 0
`define PRP_BIT_PIN_IRQ 0
`define PRP_BIT_ST_PD 0
`define PRP_BIT_ST_IRQ 1

// Reset values
`define PRP_RST_REG_PWR 16'h0000
`define PRP_RST_PIN_CFG 16'h0000
`define PRP_RST_ZERO 16'h0000

// Reset pin least low time and clock period in ns
`define PRP_RST_MIN_NS 1000
`define PRP_CLK_NS 25
`define PRP_RST_MIN_CYC ((`PRP_RST_MIN_NS + `PRP_CLK_NS - 1) / `PRP_CLK_NS)

// Cycles held in reset after the pin reads high, covers the strap synchroniser delay
`define PRP_SYNC_SETTLE_CYC 4

`endif

/* inc/prp_pkg.sv */
// Types shared by the reset and pin block
package prp_pkg;

  // Reset sequencer states, one-hot
  typedef enum logic [2:0] {
    PRP_ST_RUN = 3'b001,
    PRP_ST_HOLD = 3'b010,
    PRP_ST_REL = 3'b100
  } prp_state_e;

  typedef logic [15:0] prp_word_t;

endpackage : prp_pkg

/* design/prp_sync3.sv */
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module prp_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] q_ff;

  // Synchroniser chain
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
    end else begin
      s1_ff <= i_async;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Per bit, take the level once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
          q_ff[gi] <= RST_VAL[gi];
        end else if (s2_ff[gi] == s3_ff[gi]) begin
          q_ff[gi] <= s3_ff[gi];
        end
      end
    end
  endgenerate

  assign o_sync = q_ff;

endmodule : prp_sync3

/* design/prp_top.sv */
// Device reset sequencer, strap capture, power-down / interrupt pin and regulator control
// Functional notes
// - The reset pin must stay low at least 1 us, after which a full reset sequence runs.
// - A hardware reset returns every internal register to its default value.
// - Each hardware reset also reloads every strap-selected option.
// - A register write picks power-down input or interrupt output for the shared pin, power-down after reset.
// - In power-down role a low level on the shared pin puts the device into power-down.
// - In interrupt role the device pulls the shared pin low on an interrupt, otherwise leaves it undriven.
// - A write to the regulator control register turns the internal regulator off; here only a write with bit PRP_BIT_REG_OFF set does, a 0 there turns it on.
// - Strap pins are sampled while reset is active and set the operating modes.
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`include "prp_map.svh"
module prp_top #(
  parameter int N_EVT = 4,
  parameter int N_STRAP = 8,
  parameter int CNT_W = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_hw_rst_in_n,
  input wire logic i_pin_in,
  output logic o_pin_out,
  output logic o_pin_oe,
  input wire logic [N_STRAP-1:0] i_strap,
  input wire logic [N_EVT-1:0] i_irq_event,
  input wire logic [15:0] i_addr,
  input wire prp_pkg::prp_word_t i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output prp_pkg::prp_word_t o_rdata,
  output logic o_irq,
  output logic o_core_rst,
  output logic o_powerdown,
  output logic o_regulator_off,
  output logic [N_STRAP-1:0] o_strap_cfg
);
  import prp_pkg::*;

  localparam logic [CNT_W-1:0] RST_MIN = CNT_W'(`PRP_RST_MIN_CYC);
  localparam int RST_MIN_I = `PRP_RST_MIN_CYC;
  localparam logic [CNT_W-1:0] SETTLE = CNT_W'(`PRP_SYNC_SETTLE_CYC);

  prp_state_e state_ff;
  prp_state_e nxt_state;
  logic [CNT_W-1:0] low_cnt_ff;
  logic [CNT_W-1:0] settle_cnt_ff;
  logic rst_pin_n;
  logic pin_lvl;
  logic [N_STRAP-1:0] strap_sync;
  logic core_rst;
  logic [15:0] reg_pwr_ff;
  logic [15:0] pin_cfg_ff;
  logic [N_EVT-1:0] irq_stat_ff;
  logic [N_EVT-1:0] irq_mask_ff;
  logic [N_STRAP-1:0] strap_ff;
  logic pd_ff;
  prp_word_t rdata_ff;
  prp_word_t nxt_rdata;
  logic pin_irq_mode;
  logic irq_any;
  logic rd_stat;

  // Reset pin, shared pin and straps all come from outside the clock domain
  prp_sync3 #(
    .W(N_STRAP + 2),
    .RST_VAL({{N_STRAP{1'b0}}, 2'b11})
  ) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_async({i_strap, i_pin_in, i_hw_rst_in_n}),
    .o_sync({strap_sync, pin_lvl, rst_pin_n})
  );

  // Counts how long the reset pin has been low, saturating at the least width
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || rst_pin_n) begin
      low_cnt_ff <= '0;
    end else if (low_cnt_ff != RST_MIN) begin
      low_cnt_ff <= low_cnt_ff + CNT_W'(1);
    end
  end

  // Holds reset a few cycles after the pin reads high, so straps are settled before freezing
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || !rst_pin_n || state_ff != PRP_ST_HOLD) begin
      settle_cnt_ff <= '0;
    end else if (settle_cnt_ff != SETTLE) begin
      settle_cnt_ff <= settle_cnt_ff + CNT_W'(1);
    end
  end

  // Sequencer next state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      PRP_ST_RUN: begin
        if (!rst_pin_n && low_cnt_ff == RST_MIN - CNT_W'(1)) begin
          nxt_state = PRP_ST_HOLD;
        end
      end
      PRP_ST_HOLD: begin
        if (rst_pin_n && settle_cnt_ff == SETTLE - CNT_W'(1)) begin
          nxt_state = PRP_ST_REL;
        end
      end
      PRP_ST_REL: begin
        nxt_state = PRP_ST_RUN;
      end
      default: begin
        nxt_state = PRP_ST_HOLD;
      end
    endcase
  end

  // Sequencer state, held in reset by the system reset
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state_ff <= PRP_ST_HOLD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Core reset stays high from the qualified pin low until one clock after release
  assign core_rst = (state_ff != PRP_ST_RUN);
  assign o_core_rst = core_rst;

  // Straps follow the pins while reset is active and freeze at release
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      strap_ff <= '0;
    end else if (core_rst) begin
      strap_ff <= strap_sync;
    end
  end
  assign o_strap_cfg = strap_ff;

  // Regulator control register
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || core_rst) begin
      reg_pwr_ff <= `PRP_RST_REG_PWR;
    end else if (i_wr && i_addr == `PRP_ADDR_REG_PWR) begin
      reg_pwr_ff <= i_wdata;
    end
  end
  assign o_regulator_off = reg_pwr_ff[`PRP_BIT_REG_OFF];

  // Pin role register, power-down role by default
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || core_rst) begin
      pin_cfg_ff <= `PRP_RST_PIN_CFG;
    end else if (i_wr && i_addr == `PRP_ADDR_PIN_CFG) begin
      pin_cfg_ff <= i_wdata;
    end
  end
  assign pin_irq_mode = pin_cfg_ff[`PRP_BIT_PIN_IRQ];

  // Interrupt mask register
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || core_rst) begin
      irq_mask_ff <= '0;
    end else if (i_wr && i_addr == `PRP_ADDR_IRQ_MASK) begin
      irq_mask_ff <= i_wdata[N_EVT-1:0];
    end
  end

  // Sticky status bits, a set in the clearing cycle wins
  assign rd_stat = i_rd && (i_addr == `PRP_ADDR_IRQ_STAT);
  genvar gi;
  generate
    for (gi = 0; gi < N_EVT; gi++) begin : g_stat
      always_ff @(posedge i_clk_sys) begin
        if (i_reset || core_rst) begin
          irq_stat_ff[gi] <= 1'b0;
        end else if (i_irq_event[gi]) begin
          irq_stat_ff[gi] <= 1'b1;
        end else if (rd_stat) begin
          irq_stat_ff[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq_any = |(irq_stat_ff & irq_mask_ff);
  assign o_irq = irq_any;

  // Shared pin as open drain: only ever pulls low, in interrupt role
  assign o_pin_out = 1'b0;
  assign o_pin_oe = pin_irq_mode && irq_any;

  // Power-down request from the shared pin in its input role
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || core_rst) begin
      pd_ff <= 1'b0;
    end else begin
      pd_ff <= !pin_irq_mode && !pin_lvl;
    end
  end
  assign o_powerdown = pd_ff;

  // Read data multiplexer, unmapped offsets read zero
  always_comb begin
    nxt_rdata = `PRP_RST_ZERO;
    unique case (i_addr)
      `PRP_ADDR_REG_PWR: nxt_rdata = reg_pwr_ff;
      `PRP_ADDR_PIN_CFG: nxt_rdata = pin_cfg_ff;
      `PRP_ADDR_IRQ_STAT: nxt_rdata[N_EVT-1:0] = irq_stat_ff;
      `PRP_ADDR_IRQ_MASK: nxt_rdata[N_EVT-1:0] = irq_mask_ff;
      `PRP_ADDR_STRAP: nxt_rdata[N_STRAP-1:0] = strap_ff;
      `PRP_ADDR_STATUS: begin
        nxt_rdata[`PRP_BIT_ST_PD] = pd_ff;
        nxt_rdata[`PRP_BIT_ST_IRQ] = irq_any;
      end
      default: nxt_rdata = `PRP_RST_ZERO;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      rdata_ff <= `PRP_RST_ZERO;
    end else if (i_rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= `PRP_RST_ZERO;
    end
  end
  assign o_rdata = rdata_ff;

  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  a_reset_entry: assert property (
    (state_ff == PRP_ST_RUN && !rst_pin_n && low_cnt_ff == RST_MIN - CNT_W'(1)) |=> state_ff == PRP_ST_HOLD)
    else $error("qualified reset pin low did not start reset");

  a_rst_min_width: assert property (
    (state_ff == PRP_ST_RUN ##1 state_ff == PRP_ST_HOLD) |-> $past(!rst_pin_n, RST_MIN_I))
    else $error("reset entered on a pin pulse shorter than the least width");

  a_regs_default: assert property (
    state_ff == PRP_ST_REL |=> (reg_pwr_ff == `PRP_RST_REG_PWR && irq_mask_ff == '0 && irq_stat_ff == '0))
    else $error("registers not at default after reset release");

  a_pin_role_rst: assert property (
    state_ff == PRP_ST_REL |=> !pin_irq_mode ##0 !o_pin_oe)
    else $error("shared pin not in power-down role after reset");

  a_strap_capture: assert property (
    state_ff == PRP_ST_REL |=> strap_ff == $past(strap_sync))
    else $error("straps not captured at reset release");

  a_strap_frozen: assert property (
    (state_ff == PRP_ST_RUN && $past(state_ff) == PRP_ST_RUN) |-> $stable(strap_ff))
    else $error("strap options changed outside reset");

  a_pd_request: assert property (
    (!core_rst && !pin_irq_mode && !pin_lvl) ##1 !core_rst |-> o_powerdown)
    else $error("power-down request not taken");

  a_irq_drive: assert property (
    (pin_irq_mode && $rose(irq_any)) |-> o_pin_oe && !o_pin_out)
    else $error("interrupt did not pull the shared pin low");

  a_reg_write: assert property (
    (!core_rst && i_wr && i_addr == `PRP_ADDR_REG_PWR) ##1 !core_rst |->
      o_regulator_off == $past(i_wdata[`PRP_BIT_REG_OFF]))
    else $error("regulator control write not applied");

  a_read_clear: assert property (
    (rd_stat && !core_rst && i_irq_event == '0) ##1 (i_irq_event == '0) |-> irq_stat_ff == '0 ##1 !o_irq)
    else $error("status read did not clear the sticky bits");

  c_hw_reset: cover property (state_ff == PRP_ST_HOLD ##1 state_ff == PRP_ST_REL ##1 state_ff == PRP_ST_RUN);
  c_irq_pin: cover property (o_pin_oe ##1 rd_stat ##2 !o_pin_oe);
  c_powerdown: cover property (!pin_irq_mode && $rose(o_powerdown));
  c_regulator: cover property ($rose(o_regulator_off));

endmodule : prp_top

/* sim/prp_host_model.sv */
// Host-side model: reset pin pulses and the shared pin wire with its pull-up
`timescale 1ns/1ps
module prp_host_model (
  input wire logic i_clk_sys,
  input wire logic i_rst_go,
  input wire logic [7:0] i_rst_len,
  input wire logic i_pd_drive,
  input wire logic i_dev_oe,
  input wire logic i_dev_out,
  output logic o_hw_rst_in_n,
  output logic o_pin_wire
);
  logic [7:0] low_cnt_ff;

  // Reset pin held low for the requested number of cycles
  always_ff @(posedge i_clk_sys) begin
    if (i_rst_go) begin
      low_cnt_ff <= i_rst_len;
    end else if (low_cnt_ff != 8'h00) begin
      low_cnt_ff <= low_cnt_ff - 8'h01;
    end
  end
  assign o_hw_rst_in_n = (low_cnt_ff == 8'h00);

  // Pull-up wins unless the host or the device pulls the wire low
  assign o_pin_wire = ~i_pd_drive & ~(i_dev_oe & ~i_dev_out);
endmodule : prp_host_model

/* sim/prp_top_tb.sv */
// Self-checking bench for the reset and shared pin block
`timescale 1ns/1ps
`include "prp_map.svh"
module prp_top_tb;
  import prp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rst_go = 1'b1;
  logic [7:0] rst_len = 8'h00;
  logic pd_drive = 1'b0;
  logic hw_rst_n, pin_wire, pin_out, pin_oe, irq, core_rst, pwr_dn, reg_off, wr = 1'b0, rd = 1'b0;
  logic [7:0] strap = 8'h3C;
  logic [7:0] strap_cfg;
  logic [3:0] evt = 4'h0;
  logic [15:0] addr = 16'h0000;
  prp_word_t wdata = 16'h0000;
  prp_word_t rdata;
  int err_count = 0;
  int n_checks = 0;
  logic seen_rst;

  always #12.5 clk = ~clk;

  prp_host_model host (.i_clk_sys(clk), .i_rst_go(rst_go), .i_rst_len(rst_len), .i_pd_drive(pd_drive),
    .i_dev_oe(pin_oe), .i_dev_out(pin_out), .o_hw_rst_in_n(hw_rst_n), .o_pin_wire(pin_wire));
  prp_top DUT (.i_clk_sys(clk), .i_reset(rst), .i_hw_rst_in_n(hw_rst_n), .i_pin_in(pin_wire),
    .o_pin_out(pin_out), .o_pin_oe(pin_oe), .i_strap(strap), .i_irq_event(evt), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq), .o_core_rst(core_rst),
    .o_powerdown(pwr_dn), .o_regulator_off(reg_off), .o_strap_cfg(strap_cfg));

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", rdata, exp);
  endtask : rd_reg

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_cyc

  // Defaults after reset, unmapped read and initial strap capture
  task automatic t_defaults();
    rd_reg(`PRP_ADDR_REG_PWR, `PRP_RST_REG_PWR);
    rd_reg(`PRP_ADDR_PIN_CFG, `PRP_RST_PIN_CFG);
    rd_reg(`PRP_ADDR_IRQ_MASK, `PRP_RST_ZERO);
    rd_reg(`PRP_ADDR_IRQ_STAT, `PRP_RST_ZERO);
    rd_reg(16'h00F0, 16'h0000);
    rd_reg(`PRP_ADDR_STRAP, 16'h003C);
    chk("strap", {8'h00, strap_cfg}, 16'h003C);
  endtask : t_defaults

  // Regulator off by register write
  task automatic t_regulator();
    wr_reg(`PRP_ADDR_REG_PWR, 16'h0001);
    #1 chk("reg_off", {15'h0, reg_off}, 16'h0001);
    rd_reg(`PRP_ADDR_REG_PWR, 16'h0001);
  endtask : t_regulator

  // Power-down role: host pulls pin low
  task automatic t_powerdown();
    pd_drive <= 1'b1;
    wait_cyc(8);
    chk("pwr_dn", {15'h0, pwr_dn}, 16'h0001);
    chk("pin_oe", {15'h0, pin_oe}, 16'h0000);
    rd_reg(`PRP_ADDR_STATUS, 16'h0001 << `PRP_BIT_ST_PD);
    pd_drive <= 1'b0;
    wait_cyc(8);
    chk("pwr_dn", {15'h0, pwr_dn}, 16'h0000);
  endtask : t_powerdown

  // Interrupt role: masked event stays off the pin, unmasked one pulls it low until a status read
  task automatic t_irq();
    wr_reg(`PRP_ADDR_IRQ_MASK, 16'h0001);
    wr_reg(`PRP_ADDR_PIN_CFG, 16'h0001);
    #1 chk("wire", {15'h0, pin_wire}, 16'h0001);
    @(posedge clk);
    evt <= 4'h2;
    @(posedge clk);
    evt <= 4'h0;
    wait_cyc(1);
    chk("irq_masked", {15'h0, irq}, 16'h0000);
    chk("wire", {15'h0, pin_wire}, 16'h0001);
    @(posedge clk);
    evt <= 4'h1;
    @(posedge clk);
    evt <= 4'h0;
    wait_cyc(1);
    chk("irq", {15'h0, irq}, 16'h0001);
    chk("wire", {15'h0, pin_wire}, 16'h0000);
    rd_reg(`PRP_ADDR_STATUS, 16'h0001 << `PRP_BIT_ST_IRQ);
    pd_drive <= 1'b1;
    wait_cyc(8);
    pd_drive <= 1'b0;
    chk("pwr_dn", {15'h0, pwr_dn}, 16'h0000);
    rd_reg(`PRP_ADDR_IRQ_STAT, 16'h0003);
    #1 chk("wire", {15'h0, pin_wire}, 16'h0001);
    chk("irq", {15'h0, irq}, 16'h0000);
  endtask : t_irq

  // Reset pin: short pulse ignored, long pulse resets registers and straps
  task automatic t_hw_reset();
    seen_rst = 1'b0;
    rst_go <= 1'b1; rst_len <= 8'd20;
    @(posedge clk);
    rst_go <= 1'b0;
    repeat (40) begin
      @(posedge clk);
      seen_rst = seen_rst | core_rst;
    end
    chk("short_rst", {15'h0, seen_rst}, 16'h0000);
    strap <= 8'hA5;
    rst_go <= 1'b1; rst_len <= 8'd60;
    @(posedge clk);
    rst_go <= 1'b0;
    wait_cyc(52);
    chk("core_rst", {15'h0, core_rst}, 16'h0001);
    wait_cyc(25);
    chk("core_rst", {15'h0, core_rst}, 16'h0000);
    strap <= 8'h00;
    wait_cyc(6);
    chk("strap", {8'h00, strap_cfg}, 16'h00A5);
    chk("reg_off", {15'h0, reg_off}, 16'h0000);
    rd_reg(`PRP_ADDR_PIN_CFG, 16'h0000);
    rd_reg(`PRP_ADDR_IRQ_MASK, 16'h0000);
  endtask : t_hw_reset

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Watchdog well beyond the expected run length
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    report_and_stop();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rst_go <= 1'b0;
    wait_cyc(8);
    t_defaults();
    t_regulator();
    t_powerdown();
    t_irq();
    t_hw_reset();
    report_and_stop();
  end
endmodule : prp_top_tb
